// File: design/pch_pkg.sv
// Package: constants for the host-side card bus port controller
package pch_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   // Minimum attribute write cycle and write pulse
   localparam int ATTR_WR_CYCLE_NS = 250;
   localparam int ATTR_WR_PULSE_NS = 150;
   localparam int ATTR_RD_CYCLE_NS = 300;
   localparam int ATTR_RD_OE_NS = 150;
   // Slowest 250 ns mode strobe timings
   localparam int STROBE_W_NS = 165;
   localparam int SETUP_NS = 70;
   localparam int HOLD_NS = 30;
   localparam int RECOVERY_NS = 100;
   // Power-up personality hold time after reset release
   localparam int SEL_HOLD_NS = 1000;
   localparam int ATTR_WR_CYCLE_CYC = ns_to_cyc(ATTR_WR_CYCLE_NS);
   localparam int ATTR_WR_PULSE_CYC = ns_to_cyc(ATTR_WR_PULSE_NS);
   localparam int ATTR_RD_CYCLE_CYC = ns_to_cyc(ATTR_RD_CYCLE_NS);
   localparam int ATTR_RD_OE_CYC = ns_to_cyc(ATTR_RD_OE_NS);
   localparam int STROBE_W_CYC = ns_to_cyc(STROBE_W_NS);
   localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
   localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
   localparam int RECOVERY_CYC = ns_to_cyc(RECOVERY_NS);
   localparam int SEL_HOLD_CYC = ns_to_cyc(SEL_HOLD_NS);
   localparam int CNT_W = 8;
   // ----------------------------------------
   // Bus widths and command encoding
   // ----------------------------------------
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   typedef enum logic [2:0] {
      PCH_CMD_ATTR_RD = 3'h0,
      PCH_CMD_ATTR_WR = 3'h1,
      PCH_CMD_MEM_RD = 3'h2,
      PCH_CMD_MEM_WR = 3'h3,
      PCH_CMD_IO_RD = 3'h4,
      PCH_CMD_IO_WR = 3'h5,
      PCH_CMD_DMA_RD = 3'h6,
      PCH_CMD_DMA_WR = 3'h7
   } pch_cmd_t;
endpackage

// File: design/pch_sync3.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
module pch_sync3 (
   input wire logic clock,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level_reg <= 1'b1;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // A change counts once the second and third stages agree
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
         end
      end
   end
   assign level = level_reg;
endmodule

// File: design/pch_host_port.sv
// Host controller that drives the card bus port through its pins
`timescale 1ns/1ns
// Contract
// RQ1 - Host holds the personality select level steady through power-up reset.
// RQ2 - Card takes memory/IO personality if select high, IDE if low.
// RQ3 - Host releases chip enable or both strobes between consecutive cycles.
// RQ4 - Card never asserts wait in memory or IO cycles.
// RQ5 - In faster IO modes card gives no 16-bit or input-ack response.
// RQ6 - Card personality handles memory and direct IO cycles, chosen by strobes.
// RQ7 - IDE personality handles programmed IO and multi-word DMA transfers.
// RQ8 - Attribute writes hit configuration registers, spaced at least 250 ns.
// RQ9 - In IO mode card drives 16-bit indication low for wide ports.
// RQ10 - Card drives data only while chip enable and read strobe asserted; card model also drives it on DMA reads (dmack_n and iord_n low).
module pch_host_port
   import pch_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ide_sel,
   input wire logic req_valid,
   input wire logic [2:0] req_cmd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic rsp_wide,
   output logic rsp_err,
   output logic card_ide_mode,
   output logic card_reset,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic iord_n,
   output logic iowr_n,
   output logic reg_n,
   output logic dmack_n,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic wait_n,
   input wire logic iois16_n,
   input wire logic inpack_n
);
   // ----------------------------------------
   // State and registers
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_SEL = 3'h0,
      ST_IDLE = 3'h1,
      ST_SETUP = 3'h3,
      ST_STROBE = 3'h2,
      ST_HOLD = 3'h6,
      ST_RECOV = 3'h7
   } pch_state_t;
   pch_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [2:0] cmd_reg;
   logic ide_reg;
   logic ce_n_reg, oe_n_reg, we_n_reg, iord_n_reg, iowr_n_reg, reg_n_reg, dmack_n_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] dout_reg, rdata_reg;
   logic data_oe_reg, rsp_valid_reg, wide_reg, err_reg, creset_reg;
   logic req_ready_reg;
   logic wait_s, iois16_s, inpack_s;
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   pch_sync3 u_wait (.clock(clock), .rst(rst), .pin(wait_n), .level(wait_s));
   pch_sync3 u_io16 (.clock(clock), .rst(rst), .pin(iois16_n), .level(iois16_s));
   pch_sync3 u_inpk (.clock(clock), .rst(rst), .pin(inpack_n), .level(inpack_s));
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire take = (state_reg == ST_IDLE) && req_valid;
   // Decode the taken command directly, so the first setup cycle drives its own pins
   wire [2:0] cmd_cur = take ? req_cmd : cmd_reg;
   wire is_write = cmd_cur[0];
   wire is_attr = (cmd_cur[2:1] == 2'h0);
   wire is_io = (cmd_cur[2:1] == 2'h2);
   wire is_dma = (cmd_cur[2:1] == 2'h3);
   wire [CNT_W-1:0] strobe_cyc = is_attr ? (is_write ? CNT_W'(ATTR_WR_PULSE_CYC)
                                                  : CNT_W'(ATTR_RD_OE_CYC))
                                         : CNT_W'(STROBE_W_CYC);
   // RQ8 attribute write spacing
   // Attribute writes stretch recovery so setup+pulse+hold+recovery >= 250 ns
   wire [CNT_W-1:0] recov_cyc = (is_attr && is_write)
      ? CNT_W'(ATTR_WR_CYCLE_CYC - SETUP_CYC - ATTR_WR_PULSE_CYC - HOLD_CYC)
      : CNT_W'(RECOVERY_CYC);
   wire cnt_done = (cnt_reg == '0);
   wire strobe_first = (cnt_reg == strobe_cyc - CNT_W'(1));
   wire wait_hit = !wait_s && !ide_reg;
   // RQ5 slow-mode IO read must be acknowledged by the card
   wire ack_miss = cnt_done && is_io && !is_write && !ide_reg && inpack_s;
   // RQ7 IDE transfer classes
   wire strobe_rd = ide_reg ? !is_write : (!is_write && !is_io) ? 1'b0 : !is_write;
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_done ? cnt_reg : cnt_reg - CNT_W'(1);
      unique case (state_reg)
         // RQ1 hold select stable
         ST_SEL: if (cnt_done) begin
            state_next = ST_IDLE;
         end
         ST_IDLE: if (req_valid) begin
            state_next = ST_SETUP;
            cnt_next = CNT_W'(SETUP_CYC - 1);
         end
         ST_SETUP: if (cnt_done) begin
            state_next = ST_STROBE;
            cnt_next = strobe_cyc - CNT_W'(1);
         end
         ST_STROBE: if (cnt_done) begin
            state_next = ST_HOLD;
            cnt_next = CNT_W'(HOLD_CYC - 1);
         end
         ST_HOLD: if (cnt_done) begin
            state_next = ST_RECOV;
            cnt_next = recov_cyc - CNT_W'(1);
         end
         ST_RECOV: if (cnt_done) begin
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end
   wire strobing = (state_next == ST_STROBE);
   wire in_cycle = (state_next == ST_SETUP) || strobing || (state_next == ST_HOLD);
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_SEL;
         cnt_reg <= CNT_W'(SEL_HOLD_CYC - 1);
         creset_reg <= 1'b1;
         ide_reg <= 1'b0;
         req_ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         req_ready_reg <= (state_next == ST_IDLE);
         cnt_reg <= cnt_next;
         // RQ2 personality latched at reset end
         if (state_reg == ST_SEL && cnt_done) begin
            ide_reg <= ide_sel;
            creset_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_reg <= 3'h0;
         addr_reg <= '0;
         dout_reg <= '0;
      end else if (take) begin
         cmd_reg <= req_cmd;
         addr_reg <= req_addr;
         dout_reg <= req_wdata;
      end
   end
   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // RQ3 strobes and enable drop between cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         iord_n_reg <= 1'b1;
         iowr_n_reg <= 1'b1;
         reg_n_reg <= 1'b1;
         dmack_n_reg <= 1'b1;
         data_oe_reg <= 1'b0;
      end else begin
         // Select level rides on the read strobe until personality is fixed
         // It stays one edge past the card reset fall so the card latches a steady level
         // RQ6 class chosen by strobe
         ce_n_reg <= !(in_cycle && !is_dma);
         dmack_n_reg <= !(in_cycle && is_dma);
         reg_n_reg <= !(in_cycle && (is_attr || (is_io && !ide_reg)));
         oe_n_reg <= (state_reg == ST_SEL) ? !ide_sel
                     : !(strobing && !is_write && !is_io && !is_dma);
         we_n_reg <= !(strobing && is_write && !is_io && !is_dma);
         iord_n_reg <= !(strobing && strobe_rd && (is_io || is_dma));
         iowr_n_reg <= !(strobing && is_write && (is_io || is_dma));
         // RQ10 no contention with card read drive
         data_oe_reg <= in_cycle && is_write;
      end
   end
   // ----------------------------------------
   // Response
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_valid_reg <= 1'b0;
         rdata_reg <= '0;
         wide_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         rsp_valid_reg <= (state_reg == ST_HOLD) && cnt_done;
         // Data sampled on the last strobe cycle, well past access time
         if (state_reg == ST_STROBE && cnt_done && !is_write) begin
            rdata_reg <= data_in;
         end
         if (state_reg == ST_STROBE) begin
            // RQ4 wait asserted is a protocol error
            err_reg <= strobe_first ? (wait_hit || ack_miss)
                       : (err_reg || wait_hit || ack_miss);
            // RQ9 sixteen-bit port indication
            wide_reg <= is_io && !iois16_s;
         end
      end
   end
   assign req_ready = req_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_rdata = rdata_reg;
   assign rsp_wide = wide_reg;
   assign rsp_err = err_reg;
   assign card_ide_mode = ide_reg;
   assign card_reset = creset_reg;
   assign ce_n = ce_n_reg;
   assign oe_n = oe_n_reg;
   assign we_n = we_n_reg;
   assign iord_n = iord_n_reg;
   assign iowr_n = iowr_n_reg;
   assign reg_n = reg_n_reg;
   assign dmack_n = dmack_n_reg;
   assign addr = addr_reg;
   assign data_out = dout_reg;
   assign data_oe = data_oe_reg;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [CNT_W-1:0] gap_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gap_reg <= '1;
      end else if (!we_n_reg && !reg_n_reg) begin
         gap_reg <= '0;
      end else if (gap_reg != '1) begin
         gap_reg <= gap_reg + CNT_W'(1);
      end
   end
   property p_attr_space;
      @(posedge clock) disable iff (rst)
      $fell(we_n) && !reg_n |-> gap_reg >= CNT_W'(ATTR_WR_CYCLE_CYC - ATTR_WR_PULSE_CYC);
   endproperty
   a_attr_space: assert property (p_attr_space) else $error("attr writes too close"); // RQ8
   property p_gap;
      @(posedge clock) disable iff (rst)
      $rose(req_ready) |-> ce_n && dmack_n;
   endproperty
   a_gap: assert property (p_gap) else $error("no cycle boundary"); // RQ3
   property p_sel_hold;
      @(posedge clock) disable iff (rst)
      card_reset && !$past(rst) |-> oe_n == !ide_sel;
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select not held"); // RQ1
   property p_sel_fall;
      @(posedge clock) disable iff (rst)
      $fell(card_reset) |-> $stable(oe_n);
   endproperty
   a_sel_fall: assert property (p_sel_fall) else $error("select moved at reset end"); // RQ1
   property p_no_contend;
      @(posedge clock) disable iff (rst)
      (!oe_n || !iord_n) |-> !data_oe;
   endproperty
   a_no_contend: assert property (p_no_contend) else $error("bus contention"); // RQ10
   property p_one_strobe;
      @(posedge clock) disable iff (rst)
      !card_reset |-> $countones({~oe_n, ~we_n, ~iord_n, ~iowr_n}) <= 1;
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("two strobes"); // RQ6
   property p_dma_ack;
      @(posedge clock) disable iff (rst)
      !dmack_n |-> ce_n && card_ide_mode;
   endproperty
   a_dma_ack: assert property (p_dma_ack) else $error("dma outside ide"); // RQ7
endmodule

// File: sim/pch_card_model.sv
// Behavioural card answering the host port pins
`timescale 1ns/1ns
module pch_card_model
   import pch_pkg::*;
(
   input wire logic card_reset,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic iord_n,
   input wire logic iowr_n,
   input wire logic reg_n,
   input wire logic dmack_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   output logic [DATA_W-1:0] data_in,
   output logic wait_n,
   output logic iois16_n,
   output logic inpack_n
);
   // ----------------------------------------
   // Storage and bus drive
   // ----------------------------------------
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] dma_word;
   logic [DATA_W-1:0] last;
   logic ide_mode;
   logic space_err;
   logic clash;
   realtime t_wr;
   wire rd_sel = (!ce_n && (!oe_n || !iord_n)) || (!dmack_n && !iord_n);
   wire [DATA_W-1:0] rd_val = !dmack_n ? dma_word : mem[addr];
   initial begin
      for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 16'(i) ^ 16'h3c00;
      {ide_mode, space_err, clash, last, dma_word} = '0;
      t_wr = -1000.0;
   end
   always @(negedge card_reset) ide_mode = !oe_n;
   assign data_in = rd_sel ? rd_val : ~last;
   always @* if (rd_sel) last = rd_val;
   // Two drivers at once would corrupt the bus
   always @* if (rd_sel && data_oe) clash = 1'b1;
   assign wait_n = 1'b1;
   assign iois16_n = ide_mode || ce_n || addr[0];
   assign inpack_n = ide_mode || ce_n || iord_n;
   always @(posedge we_n or posedge iowr_n) begin
      if (!dmack_n) dma_word = data_out;
      else if (!ce_n) mem[addr] = data_out;
   end
   always @(negedge we_n) if (!ce_n && !reg_n) begin
      if ($realtime - t_wr < 250.0) space_err = 1'b1;
      t_wr = $realtime;
   end
endmodule

// File: sim/pch_host_port_test.sv
// Self-checking bench for the host port controller
`timescale 1ns/1ns
module pch_host_port_test
   import pch_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ide_sel = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_cmd = 3'h0;
   logic [ADDR_W-1:0] req_addr = 11'h000;
   logic [DATA_W-1:0] req_wdata = 16'h0000;
   logic req_ready, rsp_valid, rsp_wide, rsp_err, card_ide_mode, card_reset;
   logic ce_n, oe_n, we_n, iord_n, iowr_n, reg_n, dmack_n, data_oe;
   logic wait_n, iois16_n, inpack_n;
   logic [DATA_W-1:0] rsp_rdata, data_out, data_in;
   logic [ADDR_W-1:0] addr;
   int fail_count = 0;
   int n_checks = 0;
   pch_host_port u_dut (.clock(clock), .rst(rst), .ide_sel(ide_sel), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_wide(rsp_wide), .rsp_err(rsp_err),
      .card_ide_mode(card_ide_mode), .card_reset(card_reset), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .reg_n(reg_n), .dmack_n(dmack_n),
      .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
      .wait_n(wait_n), .iois16_n(iois16_n), .inpack_n(inpack_n));
   pch_card_model u_card (.card_reset(card_reset), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .iord_n(iord_n), .iowr_n(iowr_n), .reg_n(reg_n), .dmack_n(dmack_n), .addr(addr),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .wait_n(wait_n),
      .iois16_n(iois16_n), .inpack_n(inpack_n));
   initial begin
      forever #4 clock = ~clock;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim();
      if (fail_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // Valid is raised only once ready is seen, then dropped at the taking edge
   task automatic do_req(input logic [2:0] cmd, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd);
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_addr <= a;
      req_wdata <= wd;
      @(posedge clock);
      req_valid <= 1'b0;
      do @(posedge clock); while (rsp_valid !== 1'b1);
      chk(16'(rsp_err), 16'h0000);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset(input logic sel);
      rst <= 1'b1;
      ide_sel <= sel;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      do @(posedge clock); while (req_ready !== 1'b1);
      chk(16'(card_ide_mode), 16'(sel));
      chk(16'(u_card.ide_mode), 16'(sel));
      chk(16'(card_reset), 16'h0000);
   endtask
   task automatic t_attr();
      do_req(PCH_CMD_ATTR_WR, 11'h200, 16'h00a5);
      do_req(PCH_CMD_ATTR_WR, 11'h202, 16'h0041);
      chk(16'(u_card.space_err), 16'h0000);
      do_req(PCH_CMD_ATTR_RD, 11'h200, 16'h0000);
      chk(rsp_rdata, 16'h00a5);
      do_req(PCH_CMD_ATTR_RD, 11'h202, 16'h0000);
      chk(rsp_rdata, 16'h0041);
   endtask
   task automatic t_mem();
      do_req(PCH_CMD_MEM_WR, 11'h013, 16'hbeef);
      do_req(PCH_CMD_MEM_RD, 11'h013, 16'h0000);
      chk(rsp_rdata, 16'hbeef);
      do_req(PCH_CMD_MEM_RD, 11'h7ff, 16'h0000);
      chk(rsp_rdata, 16'h07ff ^ 16'h3c00);
      chk(16'(u_card.clash), 16'h0000);
   endtask
   task automatic t_io();
      logic [ADDR_W-1:0] a;
      for (int i = 0; i < 2; i++) begin
         a = 11'h0a4 + 11'(i);
         do_req(PCH_CMD_IO_WR, a, 16'hc300 | 16'(a));
         do_req(PCH_CMD_IO_RD, a, 16'h0000);
         chk(rsp_rdata, 16'hc300 | 16'(a));
         chk(16'(rsp_wide), 16'(!a[0]));
      end
   endtask
   task automatic t_ide();
      do_req(PCH_CMD_DMA_WR, 11'h000, 16'h5a3c);
      do_req(PCH_CMD_DMA_RD, 11'h000, 16'h0000);
      chk(rsp_rdata, 16'h5a3c);
      do_req(PCH_CMD_IO_RD, 11'h006, 16'h0000);
      chk(rsp_rdata, 16'h0006 ^ 16'h3c00);
      chk(16'(rsp_wide), 16'h0000);
      chk(16'(u_card.clash), 16'h0000);
   endtask
   initial begin
      t_reset(1'b0);
      t_attr();
      t_mem();
      t_io();
      t_reset(1'b1);
      t_ide();
      end_sim();
   end
   // A hang counts as a mismatch; the run needs roughly 1500 cycles
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      end_sim();
   end
endmodule
